// file: inc/udt_pkg.sv
/*
  Shared constants and encodings of the serial decode and trigger block.
  Assumes a single 10 MHz system clock.
*/
package udt_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int NUM_BUS = 4;
  localparam int NUM_CHAN = 29;
  localparam logic [24:0] RATE_MIN = 25'h000012C;
  localparam logic [24:0] RATE_MAX = 25'h1312D00;
  localparam logic [24:0] RATE_RESET = 25'h0002580;
  localparam logic [19:0] GAP_MIN_US = 20'h00001;
  localparam logic [19:0] GAP_MAX_US = 20'hF4240;
  localparam logic [19:0] GAP_RESET_US = 20'h00271;
  localparam int CYCLES_PER_US = CLK_HZ / 1000000;
  localparam logic [3:0] WIDTH_MIN = 4'h5;
  localparam logic [3:0] WIDTH_PAR_MAX = 4'h8;
  localparam logic [3:0] WIDTH_MAX = 4'h9;
  localparam logic [3:0] WIDTH_RESET = 4'h8;
  localparam logic [12:0] SKIP_MIN = 13'h0001;
  localparam logic [12:0] SKIP_MAX = 13'h1000;
  localparam logic [12:0] SKIP_RESET = 13'h0001;
  localparam logic [4:0] SRC_RESET = 5'h00;

  typedef enum logic [1:0] {PKT_NONE = 2'h0, PKT_END_WORD = 2'h1, PKT_TIMEOUT = 2'h2} udt_pkt_e;
  typedef enum logic [2:0] {
    PAR_NONE = 3'h0, PAR_ODD = 3'h1, PAR_EVEN = 3'h2,
    PAR_FIXED_ONE = 3'h3, PAR_FIXED_ZERO = 3'h4, PAR_IGNORED = 3'h5
  } udt_parity_e;
  typedef enum logic {LINE_RESTS_LOW = 1'h0, LINE_RESTS_HIGH = 1'h1} udt_polarity_e;
  typedef enum logic [1:0] {ONE_STOP_BIT = 2'h0, ONE_AND_HALF_STOP_BITS = 2'h1, TWO_STOP_BITS = 2'h2} udt_stop_e;
  typedef enum logic [2:0] {
    EQUAL_OP = 3'h0, NOT_EQUAL_OP = 3'h1, LESS_OP = 3'h2,
    LESS_OR_EQUAL_OP = 3'h3, GREATER_OP = 3'h4, GREATER_OR_EQUAL_OP = 3'h5
  } udt_op_e;
  typedef enum logic [2:0] {
    START_BIT_MATCH = 3'h0, PACKET_BEGIN_MATCH = 3'h1, DATA_MATCH = 3'h2,
    PARITY_ERROR_MATCH = 3'h3, LINE_BREAK_MATCH = 3'h4, STOP_FAULT_MATCH = 3'h5
  } udt_trig_e;
  typedef enum logic [2:0] {
    ST_OK = 3'h0, ST_START_END_ERR = 3'h1, ST_FRAME_ERR = 3'h2, ST_BREAK = 3'h3,
    ST_START_ERR = 3'h4, ST_STOP_ERR = 3'h5, ST_PARITY_ERR = 3'h6, ST_INCOMPLETE = 3'h7
  } udt_status_e;
  localparam logic TRIG_LINE_TX = 1'h0;
endpackage

// file: hdl/udt_half_tick.sv
/*
  Half-bit tick generator: a phase accumulator stepping by twice the bit rate.
  Assumes the bit rate input is already clamped; held at zero phase while hold_in is high.
*/
`timescale 1ns/1ps
module udt_half_tick (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic hold_in,
  input wire logic [24:0] rate_in,
  output logic tick_out
);
  localparam logic [26:0] CLK_W = 27'(udt_pkg::CLK_HZ);
  typedef struct packed {
    logic [26:0] acc;
    logic tick;
  } udt_tick_s;
  udt_tick_s r;
  udt_tick_s next_r;
  logic [26:0] sum;

  always_comb
  begin
    next_r = r;
    sum = r.acc + {1'h0, rate_in, 1'h0};
    next_r.tick = 1'h0;
    if (hold_in)
    begin
      next_r.acc = 27'h0000000;
    end
    else if (sum >= CLK_W)
    begin
      next_r.tick = 1'h1;
      next_r.acc = ((sum - CLK_W) >= CLK_W) ? (CLK_W - 27'h0000001) : (sum - CLK_W);
    end
    else
    begin
      next_r.acc = sum;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      r <= '0;
    else
      r <= next_r;
  end

  assign tick_out = r.tick;
endmodule

// file: hdl/udt_word_rx.sv
/*
  Word receiver for one logical serial line: start, data, parity and stop bits.
  Assumes line_in is the logical level (idle 1) and half_tick_in comes every half bit.
*/
`timescale 1ns/1ps
module udt_word_rx (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic line_in,
  input wire logic half_tick_in,
  input wire logic [3:0] width_in,
  input wire logic [2:0] parity_in,
  input wire logic [1:0] stop_in,
  output logic hunting_out,
  output logic start_out,
  output logic word_valid_out,
  output logic [8:0] data_out,
  output logic [2:0] status_out
);
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_START = 3'h1, S_DATA = 3'h2, S_PAR = 3'h3,
    S_STOP = 3'h4, S_STOP2 = 3'h5, S_WAIT = 3'h6
  } udt_rx_e;
  typedef struct packed {
    udt_rx_e st;
    logic ph;
    logic [3:0] cnt;
    logic [8:0] data;
    logic all_zero;
    logic par_bit;
    logic par_err;
    logic stop_err;
    logic start;
    logic valid;
    logic [2:0] status;
  } udt_rx_s;
  udt_rx_s r;
  udt_rx_s next_r;
  logic [3:0] w;
  logic mid;
  logic expect_par;

  always_comb
  begin
    next_r = r;
    next_r.start = 1'h0;
    next_r.valid = 1'h0;
    w = width_in;
    if (w < udt_pkg::WIDTH_MIN)
      w = udt_pkg::WIDTH_MIN;
    if (w > udt_pkg::WIDTH_MAX)
      w = udt_pkg::WIDTH_MAX;
    if (w == udt_pkg::WIDTH_MAX && parity_in != udt_pkg::PAR_NONE)
      w = udt_pkg::WIDTH_PAR_MAX;
    mid = half_tick_in & ~r.ph;
    expect_par = 1'h0;
    case (parity_in)
      udt_pkg::PAR_ODD: expect_par = ~(^r.data);
      udt_pkg::PAR_EVEN: expect_par = ^r.data;
      udt_pkg::PAR_FIXED_ONE: expect_par = 1'h1;
      default: expect_par = 1'h0;
    endcase
    if (half_tick_in && r.st != S_IDLE && r.st != S_WAIT)
      next_r.ph = ~r.ph;
    case (r.st)
      S_IDLE:
      begin
        if (!line_in)
        begin
          next_r.st = S_START;
          next_r.start = 1'h1;
          next_r.ph = 1'h0;
          next_r.cnt = 4'h0;
          next_r.data = 9'h000;
          next_r.all_zero = 1'h1;
          next_r.par_bit = 1'h0;
          next_r.par_err = 1'h0;
          next_r.stop_err = 1'h0;
        end
      end
      S_START:
      begin
        if (mid && line_in)
        begin
          next_r.valid = 1'h1;
          next_r.status = udt_pkg::ST_START_ERR;
          next_r.st = S_IDLE;
        end
        else if (mid)
          next_r.st = S_DATA;
      end
      S_DATA:
      begin
        if (mid)
        begin
          next_r.data[r.cnt] = line_in;
          next_r.all_zero = r.all_zero & ~line_in;
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt == w - 4'h1)
            next_r.st = (parity_in == udt_pkg::PAR_NONE) ? S_STOP : S_PAR;
        end
      end
      S_PAR:
      begin
        if (mid)
        begin
          next_r.par_bit = line_in;
          next_r.all_zero = r.all_zero & ~line_in;
          next_r.par_err = (parity_in != udt_pkg::PAR_IGNORED) && (line_in != expect_par);
          next_r.st = S_STOP;
        end
      end
      S_STOP:
      begin
        if (mid)
        begin
          next_r.stop_err = ~line_in;
          next_r.all_zero = r.all_zero & ~line_in;
          next_r.st = (stop_in == udt_pkg::ONE_STOP_BIT) ? S_WAIT : S_STOP2;
        end
      end
      S_STOP2:
      begin
        if ((stop_in == udt_pkg::ONE_AND_HALF_STOP_BITS && half_tick_in) || mid)
        begin
          next_r.stop_err = r.stop_err | ~line_in;
          next_r.all_zero = r.all_zero & ~line_in;
          next_r.st = S_WAIT;
        end
      end
      S_WAIT:
      begin
        if (line_in)
          next_r.st = S_IDLE;
      end
      default: next_r.st = S_IDLE;
    endcase
    if (next_r.st == S_WAIT && r.st != S_WAIT)
    begin
      next_r.valid = 1'h1;
      if (next_r.all_zero)
        next_r.status = udt_pkg::ST_BREAK;
      else if (next_r.stop_err)
        next_r.status = udt_pkg::ST_STOP_ERR;
      else if (next_r.par_err)
        next_r.status = udt_pkg::ST_PARITY_ERR;
      else
        next_r.status = udt_pkg::ST_OK;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      r <= '0;
    else
      r <= next_r;
  end

  assign hunting_out = (r.st == S_IDLE);
  assign start_out = r.start;
  assign word_valid_out = r.valid;
  assign data_out = r.data;
  assign status_out = r.status;

  a_fixed_one_parity: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (r.st == S_PAR && mid && parity_in == udt_pkg::PAR_FIXED_ONE) |=> (r.par_err == !r.par_bit))
    else $error("fixed-one parity error flag wrong");
  a_fixed_zero_parity: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (r.st == S_PAR && mid && parity_in == udt_pkg::PAR_FIXED_ZERO) |=> (r.par_err == r.par_bit))
    else $error("fixed-zero parity error flag wrong");
  a_ignored_parity: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (r.valid && $past(parity_in) == udt_pkg::PAR_IGNORED) |-> (r.status != udt_pkg::ST_PARITY_ERR))
    else $error("parity error reported while parity ignored");
  a_nine_bit_word: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (r.valid && $stable(parity_in) && parity_in != udt_pkg::PAR_NONE) |-> !r.data[8])
    else $error("ninth data bit used with parity");
  a_start_on_low: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    r.start |-> $past(r.st == S_IDLE && !line_in))
    else $error("start pulse without low line in idle");
  a_break_low_stop: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (r.valid && r.status == udt_pkg::ST_BREAK) |-> !$past(line_in))
    else $error("break reported with high final stop sample");
endmodule

// file: hdl/udt_decoder_top.sv
/*
  Four-bus serial decoder with packet grouping and one trigger unit.
  Assumes all channel inputs are synchronous to sys_clk_in; settings are written by strobes.
*/
// What this block does
// - Bit rate 300 to 20000000 bps, default 9600, drives bit timing.
// - Packet grouping none, end word or idle timeout; timeout after reset.
// - After a word equals the end pattern, next start bit begins a packet.
// - After idle longer than gap (1us to 1s, default 625us) next start begins packet.
// - Parity none, odd, even, fixed one, fixed zero or ignored; none after reset.
// - Fixed-one parity expects a 1; mismatch is a parity error.
// - Fixed-zero parity expects a 0; mismatch is a parity error.
// - Ignored parity keeps the parity bit slot but never reports parity errors.
// - Idle is logic 1, start bit logic 0; polarity maps logic to level.
// - Polarity rests low or rests high; rests high after reset.
// - One, one and a half or two stop bits; one after reset.
// - Data width 5 to 8, or 9 without parity; 8 after reset.
// - Receive and transmit lines each pick their own source channel.
// - Trigger pattern is read least significant bit first when compared.
// - Pattern trigger skips 1 to 4096 leading words, default 1.
// - Compare operators equal, unequal, less, less-equal, greater, greater-equal; equal default.
// - Trigger watches transmit or receive line; transmit after reset.
// - Trigger on start, packet start, pattern, parity error, break or stop error.
// - Four independent decoder instances, each with its own settings.
// - Each word carries a status from the defined status set.
`timescale 1ns/1ps
module udt_decoder_top #(
  parameter int NUM_CHAN = udt_pkg::NUM_CHAN,
  parameter int CYCLES_PER_US = udt_pkg::CYCLES_PER_US
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [NUM_CHAN-1:0] chan_in,
  input wire logic cfg_write_in,
  input wire logic [1:0] cfg_bus_in,
  input wire logic [24:0] cfg_bit_rate_in,
  input wire logic [1:0] cfg_packet_mode_in,
  input wire logic [8:0] cfg_packet_end_pattern_in,
  input wire logic [19:0] cfg_packet_gap_limit_in,
  input wire logic [2:0] cfg_parity_in,
  input wire logic cfg_line_rests_high_in,
  input wire logic [1:0] cfg_stop_bit_count_in,
  input wire logic [3:0] cfg_word_data_width_in,
  input wire logic [4:0] cfg_rx_source_in,
  input wire logic [4:0] cfg_tx_source_in,
  input wire logic trig_write_in,
  input wire logic [1:0] trig_bus_in,
  input wire logic [8:0] trig_pattern_in,
  input wire logic [12:0] trig_word_skip_count_in,
  input wire logic [2:0] trig_pattern_compare_operator_in,
  input wire logic trig_line_in,
  input wire logic [2:0] trig_type_in,
  output logic trigger_out,
  output logic word_valid_out,
  output logic [8:0] word_data_out,
  output logic [2:0] word_status_out,
  output logic packet_begin_out
);
  localparam int NRX = 2 * udt_pkg::NUM_BUS;
  localparam logic [12:0] IDX_ONE = 13'h0001;

  typedef struct packed {
    logic [3:0][24:0] rate;
    logic [3:0][1:0] pkt_mode;
    logic [3:0][8:0] end_pat;
    logic [3:0][19:0] gap_us;
    logic [3:0][2:0] parity;
    logic [3:0] rests_high;
    logic [3:0][1:0] stop;
    logic [3:0][3:0] width;
    logic [3:0][4:0] rx_src;
    logic [3:0][4:0] tx_src;
    logic [8:0] pat;
    logic [12:0] skip;
    logic [2:0] op;
    logic line;
    logic [2:0] kind;
    logic [1:0] bus;
    logic [NRX-1:0] armed;
    logic [NRX-1:0][23:0] idle_cnt;
    logic [12:0] word_idx;
    logic trigger;
    logic word_valid;
    logic [8:0] word_data;
    logic [2:0] word_status;
    logic packet_begin;
  } udt_top_s;
  udt_top_s r;
  udt_top_s next_r;

  logic [NRX-1:0] line_lvl;
  logic [NRX-1:0] tick;
  logic [NRX-1:0] hunting;
  logic [NRX-1:0] start;
  logic [NRX-1:0] valid;
  logic [NRX-1:0][8:0] data;
  logic [NRX-1:0][2:0] status;
  logic [NRX-1:0] begin_now;
  logic [2:0] sel;
  logic [1:0] sb;
  logic [27:0] gap_cyc;
  logic [8:0] mask;
  logic [8:0] pat_m;
  logic hit;

  // Source selection, polarity and per-line receivers
  for (genvar g = 0; g < NRX; g++)
  begin : g_rx
    logic [4:0] src;
    logic pin;
    assign src = g[0] ? r.rx_src[g/2] : r.tx_src[g/2];
    assign pin = (int'(src) < NUM_CHAN) ? chan_in[src] : 1'h0;
    assign line_lvl[g] = r.rests_high[g/2] ? pin : ~pin;

    udt_half_tick u_tick (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .hold_in(hunting[g]),
      .rate_in(r.rate[g/2]),
      .tick_out(tick[g])
    );

    udt_word_rx u_rx (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .line_in(line_lvl[g]),
      .half_tick_in(tick[g]),
      .width_in(r.width[g/2]),
      .parity_in(r.parity[g/2]),
      .stop_in(r.stop[g/2]),
      .hunting_out(hunting[g]),
      .start_out(start[g]),
      .word_valid_out(valid[g]),
      .data_out(data[g]),
      .status_out(status[g])
    );

    a_packet_on_start: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      begin_now[g] |-> (start[g] && r.pkt_mode[g/2] != udt_pkg::PKT_NONE && r.armed[g]))
      else $error("packet begin without armed start bit");
  end

  always_comb
  begin
    next_r = r;
    next_r.trigger = 1'h0;
    next_r.word_valid = 1'h0;
    next_r.packet_begin = 1'h0;
    begin_now = '0;
    gap_cyc = 28'h0000000;
    sel = {r.bus, r.line};
    sb = 2'h0;
    mask = 9'h000;
    pat_m = 9'h000;
    hit = 1'h0;

    // Packet grouping per line
    for (int i = 0; i < NRX; i++)
    begin
      sb = 2'(i / 2);
      gap_cyc = 28'(r.gap_us[sb]) * 28'(CYCLES_PER_US);
      case (r.pkt_mode[sb])
        udt_pkg::PKT_END_WORD:
        begin
          if (start[i] && r.armed[i])
          begin
            begin_now[i] = 1'h1;
            next_r.armed[i] = 1'h0;
          end
          if (valid[i] && data[i] == r.end_pat[sb])
            next_r.armed[i] = 1'h1;
        end
        udt_pkg::PKT_TIMEOUT:
        begin
          if (start[i])
          begin
            begin_now[i] = r.armed[i];
            next_r.armed[i] = 1'h0;
            next_r.idle_cnt[i] = 24'h000000;
          end
          else if (hunting[i])
          begin
            if (28'(r.idle_cnt[i]) >= gap_cyc)
              next_r.armed[i] = 1'h1;
            else
              next_r.idle_cnt[i] = r.idle_cnt[i] + 24'h000001;
          end
        end
        default:
        begin
          next_r.armed[i] = 1'h1;
          next_r.idle_cnt[i] = 24'h000000;
        end
      endcase
    end

    // Word position within the packet on the observed line
    if (begin_now[sel])
      next_r.word_idx = 13'h0000;
    else if (valid[sel] && r.word_idx != udt_pkg::SKIP_MAX)
      next_r.word_idx = r.word_idx + IDX_ONE;

    // Pattern compare, value weighted least significant bit first
    mask = 9'h1FF >> (4'h9 - ((r.width[r.bus] > udt_pkg::WIDTH_MAX) ? udt_pkg::WIDTH_MAX :
      (r.width[r.bus] < udt_pkg::WIDTH_MIN) ? udt_pkg::WIDTH_MIN : r.width[r.bus]));
    pat_m = r.pat & mask;
    case (r.op)
      udt_pkg::NOT_EQUAL_OP: hit = data[sel] != pat_m;
      udt_pkg::LESS_OP: hit = data[sel] < pat_m;
      udt_pkg::LESS_OR_EQUAL_OP: hit = data[sel] <= pat_m;
      udt_pkg::GREATER_OP: hit = data[sel] > pat_m;
      udt_pkg::GREATER_OR_EQUAL_OP: hit = data[sel] >= pat_m;
      default: hit = data[sel] == pat_m;
    endcase

    // Trigger condition on the selected bus and line
    case (r.kind)
      udt_pkg::START_BIT_MATCH: next_r.trigger = start[sel];
      udt_pkg::PACKET_BEGIN_MATCH: next_r.trigger = begin_now[sel];
      udt_pkg::DATA_MATCH: next_r.trigger = valid[sel] && r.word_idx == r.skip && hit;
      udt_pkg::PARITY_ERROR_MATCH: next_r.trigger = valid[sel] && status[sel] == udt_pkg::ST_PARITY_ERR;
      udt_pkg::LINE_BREAK_MATCH: next_r.trigger = valid[sel] && status[sel] == udt_pkg::ST_BREAK;
      udt_pkg::STOP_FAULT_MATCH: next_r.trigger = valid[sel] && status[sel] == udt_pkg::ST_STOP_ERR;
      default: next_r.trigger = 1'h0;
    endcase

    // Observed line word stream
    next_r.packet_begin = begin_now[sel];
    next_r.word_valid = valid[sel];
    if (valid[sel])
    begin
      next_r.word_data = data[sel];
      next_r.word_status = status[sel];
    end

    // Per-bus configuration writes
    if (cfg_write_in)
    begin
      next_r.rate[cfg_bus_in] = (cfg_bit_rate_in < udt_pkg::RATE_MIN) ? udt_pkg::RATE_MIN :
        (cfg_bit_rate_in > udt_pkg::RATE_MAX) ? udt_pkg::RATE_MAX : cfg_bit_rate_in;
      next_r.pkt_mode[cfg_bus_in] = (cfg_packet_mode_in > udt_pkg::PKT_TIMEOUT) ? udt_pkg::PKT_TIMEOUT :
        cfg_packet_mode_in;
      next_r.end_pat[cfg_bus_in] = cfg_packet_end_pattern_in;
      next_r.gap_us[cfg_bus_in] = (cfg_packet_gap_limit_in < udt_pkg::GAP_MIN_US) ? udt_pkg::GAP_MIN_US :
        (cfg_packet_gap_limit_in > udt_pkg::GAP_MAX_US) ? udt_pkg::GAP_MAX_US : cfg_packet_gap_limit_in;
      next_r.parity[cfg_bus_in] = (cfg_parity_in > udt_pkg::PAR_IGNORED) ? udt_pkg::PAR_NONE : cfg_parity_in;
      next_r.rests_high[cfg_bus_in] = cfg_line_rests_high_in;
      next_r.stop[cfg_bus_in] = (cfg_stop_bit_count_in > udt_pkg::TWO_STOP_BITS) ? udt_pkg::TWO_STOP_BITS :
        cfg_stop_bit_count_in;
      next_r.width[cfg_bus_in] = cfg_word_data_width_in;
      next_r.rx_src[cfg_bus_in] = cfg_rx_source_in;
      next_r.tx_src[cfg_bus_in] = cfg_tx_source_in;
      for (int i = 0; i < NRX; i++)
      begin
        if (2'(i / 2) == cfg_bus_in)
        begin
          next_r.armed[i] = 1'h1;
          next_r.idle_cnt[i] = 24'h000000;
        end
      end
    end

    // Trigger settings are one shared set; the bus named with them is the bus watched
    if (trig_write_in)
    begin
      next_r.bus = trig_bus_in;
      next_r.pat = trig_pattern_in;
      next_r.skip = (trig_word_skip_count_in < udt_pkg::SKIP_MIN) ? udt_pkg::SKIP_MIN :
        (trig_word_skip_count_in > udt_pkg::SKIP_MAX) ? udt_pkg::SKIP_MAX : trig_word_skip_count_in;
      next_r.op = (trig_pattern_compare_operator_in > udt_pkg::GREATER_OR_EQUAL_OP) ? udt_pkg::EQUAL_OP :
        trig_pattern_compare_operator_in;
      next_r.line = trig_line_in;
      next_r.kind = (trig_type_in > udt_pkg::STOP_FAULT_MATCH) ? udt_pkg::START_BIT_MATCH : trig_type_in;
      next_r.word_idx = 13'h0000;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      r <= '0;
      r.rate <= {4{udt_pkg::RATE_RESET}};
      r.pkt_mode <= {4{udt_pkg::PKT_TIMEOUT}};
      r.gap_us <= {4{udt_pkg::GAP_RESET_US}};
      r.parity <= {4{udt_pkg::PAR_NONE}};
      r.rests_high <= {4{udt_pkg::LINE_RESTS_HIGH}};
      r.stop <= {4{udt_pkg::ONE_STOP_BIT}};
      r.width <= {4{udt_pkg::WIDTH_RESET}};
      r.rx_src <= {4{udt_pkg::SRC_RESET}};
      r.tx_src <= {4{udt_pkg::SRC_RESET}};
      r.skip <= udt_pkg::SKIP_RESET;
      r.op <= udt_pkg::EQUAL_OP;
      r.line <= udt_pkg::TRIG_LINE_TX;
      r.kind <= udt_pkg::START_BIT_MATCH;
      r.armed <= '1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign trigger_out = r.trigger;
  assign word_valid_out = r.word_valid;
  assign word_data_out = r.word_data;
  assign word_status_out = r.word_status;
  assign packet_begin_out = r.packet_begin;

  a_start_trigger: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (r.kind == udt_pkg::START_BIT_MATCH && start[{r.bus, r.line}] && !trig_write_in) |=> trigger_out)
    else $error("start bit did not trigger");
  a_skip_position: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (trigger_out && $past(r.kind) == udt_pkg::DATA_MATCH) |-> ($past(r.word_idx) == $past(r.skip)))
    else $error("pattern trigger at wrong word position");
  a_rate_range: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (r.rate[cfg_bus_in] >= udt_pkg::RATE_MIN) && (r.rate[cfg_bus_in] <= udt_pkg::RATE_MAX))
    else $error("bit rate outside range");
  a_bus_isolated: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    cfg_write_in |=> (r.rate[~$past(cfg_bus_in)] == $past(r.rate[~cfg_bus_in])))
    else $error("write disturbed another bus");
endmodule

// file: verification/udt_line_model.sv
/*
  Far-side model: equipment sending serial words on one line.
  Assumes 1 Mbps timing, so one bit lasts 1000 ns, and that calls start on a falling clock edge.
*/
`timescale 1ns/1ps
module udt_line_model (
  output logic line_out
);
  initial line_out = 1'b1; // Idle is logic 1
  task automatic send(input logic [7:0] d, input logic pb, input logic wp, input logic sb);
    line_out = 1'b0; // Start bit
    #1000;
    for (int i = 0; i < 8; i++)
    begin
      line_out = d[i];
      #1000;
    end
    if (wp)
    begin
      line_out = pb;
      #1000;
    end
    line_out = sb;
    #1000;
    line_out = 1'b1;
    #3000;
  endtask
endmodule

// file: verification/udt_decoder_top_tb_top.sv
/*
  Self-checking bench of the serial decode and trigger block.
  Assumes the line model drives channel 0 and the trigger watches bus 0.
*/
`timescale 1ns/1ps
module udt_decoder_top_tb_top;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cfg_write_in = 1'b0;
  logic trig_write_in = 1'b0;
  logic [2:0] cfg_parity = 3'h0;
  logic [2:0] trig_type = 3'h0;
  logic [1:0] cfg_bus = 2'h0;
  logic [24:0] rate = 25'h00F4240;
  logic [1:0] pkt_mode = 2'h2;
  logic [8:0] end_pat = 9'h000;
  logic [19:0] gap = 20'h00271;
  logic rests_high = 1'h1;
  logic [1:0] stop_cnt = 2'h0;
  logic [3:0] width = 4'h8;
  logic [4:0] rx_src = 5'h00;
  logic [4:0] tx_src = 5'h00;
  logic [1:0] trig_bus = 2'h0;
  logic [8:0] trig_pat = 9'h000;
  logic [12:0] skip = 13'h0001;
  logic [2:0] op = 3'h0;
  logic trig_line = 1'h0;
  logic line;
  logic trigger_out;
  logic word_valid_out;
  logic [8:0] word_data_out;
  logic [2:0] word_status_out;
  logic packet_begin_out;
  logic tv;
  logic [2:0] sv;
  logic [8:0] dv;
  int miscompares = 0;
  int cmp_count = 0;
  int trig_cnt = 0;
  int pkt_cnt = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  always @(negedge sys_clk_in)
  begin
    trig_cnt += (trigger_out === 1'b1);
    pkt_cnt += (packet_begin_out === 1'b1);
  end
  udt_line_model model (.line_out(line));
  udt_decoder_top #(.CYCLES_PER_US(1)) DUT (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .chan_in({28'h0000000, line}), .cfg_write_in(cfg_write_in), .cfg_bus_in(cfg_bus),
    .cfg_bit_rate_in(rate), .cfg_packet_mode_in(pkt_mode), .cfg_packet_end_pattern_in(end_pat),
    .cfg_packet_gap_limit_in(gap), .cfg_parity_in(cfg_parity), .cfg_line_rests_high_in(rests_high),
    .cfg_stop_bit_count_in(stop_cnt), .cfg_word_data_width_in(width), .cfg_rx_source_in(rx_src),
    .cfg_tx_source_in(tx_src), .trig_write_in(trig_write_in), .trig_bus_in(trig_bus),
    .trig_pattern_in(trig_pat), .trig_word_skip_count_in(skip),
    .trig_pattern_compare_operator_in(op), .trig_line_in(trig_line), .trig_type_in(trig_type),
    .trigger_out(trigger_out), .word_valid_out(word_valid_out), .word_data_out(word_data_out),
    .word_status_out(word_status_out), .packet_begin_out(packet_begin_out));
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cfg(input logic [2:0] p);
    @(negedge sys_clk_in);
    cfg_parity = p;
    cfg_write_in = 1'b1;
    @(negedge sys_clk_in);
    cfg_write_in = 1'b0;
  endtask
  task automatic run(input logic [7:0] d, input logic pb, input logic wp, input logic sb);
    int n = 0;
    fork
      model.send(d, pb, wp, sb);
      begin
        @(negedge sys_clk_in);
        while (word_valid_out !== 1'b1 && n < 300)
        begin
          n++;
          @(negedge sys_clk_in);
        end
        tv = trigger_out;
        dv = word_data_out;
        sv = word_status_out;
        chk("word wait", 9'h000, (n == 300) ? 9'h1FF : 9'h000);
      end
    join
  endtask
  task automatic t_start;
    cfg(udt_pkg::PAR_NONE);
    run(8'hA5, 1'b0, 1'b0, 1'b1);
    chk("data", 9'h0A5, dv);
    chk("status", 9'h000, {6'h00, sv});
    chk("start trig", 9'h001, trig_cnt[8:0]);
    chk("pkt begin", 9'h001, pkt_cnt[8:0]);
  endtask
  task automatic t_parity;
    logic [2:0] pm [4] = '{udt_pkg::PAR_FIXED_ONE, udt_pkg::PAR_FIXED_ZERO, udt_pkg::PAR_IGNORED, udt_pkg::PAR_EVEN};
    logic pbit [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    logic [2:0] ex [4] = '{3'h6, 3'h6, 3'h0, 3'h6};
    @(negedge sys_clk_in);
    trig_type = udt_pkg::PARITY_ERROR_MATCH;
    trig_write_in = 1'b1;
    @(negedge sys_clk_in);
    trig_write_in = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      cfg(pm[i]);
      run(8'hA5, pbit[i], 1'b1, 1'b1);
      chk("parity status", {6'h00, ex[i]}, {6'h00, sv});
      chk("parity trig", {8'h00, ex[i] == 3'h6}, {8'h00, tv});
    end
  endtask
  task automatic t_stop;
    cfg(udt_pkg::PAR_NONE);
    run(8'h3C, 1'b0, 1'b0, 1'b0);
    chk("stop status", 9'h005, {6'h00, sv});
  endtask
  task automatic t_pattern;
    pkt_mode = 2'h1;
    end_pat = 9'h0FF;
    trig_pat = 9'h03C;
    @(negedge sys_clk_in);
    trig_type = udt_pkg::DATA_MATCH;
    trig_write_in = 1'b1;
    @(negedge sys_clk_in);
    trig_write_in = 1'b0;
    cfg(udt_pkg::PAR_NONE);
    run(8'hA5, 1'b0, 1'b0, 1'b1);
    chk("first word no trig", 9'h000, {8'h00, tv});
    run(8'h3C, 1'b0, 1'b0, 1'b1);
    chk("pattern data", 9'h03C, dv);
    chk("pattern trig", 9'h001, {8'h00, tv});
    chk("pkt count", 9'h007, pkt_cnt[8:0]);
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    miscompares++;
    stop_test();
  end
  initial
  begin
    repeat (20) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    t_start();
    t_parity();
    t_stop();
    t_pattern();
    stop_test();
  end
endmodule
